// ==== design/ssp_baud_gen.sv ====
// Purpose : Divider making the half-period tick of the master shift clock
// Assumes : Divisor stable while running
// Notes   : Tick every divisor+1 cycles; count restarts whenever run drops
`timescale 1ns/1ns
`default_nettype none
module ssp_baud_gen
(
   input  wire logic  sys_clk_i,
   input  wire logic  nrst_i,
   ssp_baud_if.gen    bif
);
   import ssp_pkg::*;

   ssp_byte_t count;

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i || !bif.run)
      begin
         count    <= RST_BYTE;
         bif.tick <= 1'b0;
      end
      else if (count == bif.divisor)
      begin
         count    <= RST_BYTE;
         bif.tick <= 1'b1;
      end
      else
      begin
         count    <= count + 8'h01;
         bif.tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== design/ssp_baud_if.sv ====
// Purpose : Carries the run request, divisor and tick between port and divider
// Assumes : Both ends on sys_clk_i
// Notes   : Tick is a one-cycle enable pulse
`timescale 1ns/1ns
`default_nettype none
interface ssp_baud_if;
   logic                run;
   ssp_pkg::ssp_byte_t  divisor;
   logic                tick;

   modport ctl (output run, output divisor, input tick);
   modport gen (input run, input divisor, output tick);
endinterface
`default_nettype wire

// ==== design/ssp_pkg.sv ====
// Purpose : Shared constants, types and helpers for the synchronous serial port
// Assumes : Eight-bit register port, one core clock
// Notes   : Register indices are byte addresses on the plain register port
//
// Functional notes
// - Receive starts only when a receive enable set
// - Sample data on shift clock falling edge
// - Master single-word enable receives exactly one word
// - Continuous enable receives until software clears it
// - Continuous enable wins when both are set
// - Clock source bit selects master or slave
// - Slave shifts on the externally driven clock
// - Slave keeps shifting during low-power modes
// - First buffered word loads shifter at once
// - Buffer-empty flag sets when second word loads
// - Buffer-empty flag with enable wakes the core
// - Slave ignores single-word receive enable
// - Continuous-enabled slave receives while core sleeps
// - Finished word moves to receive buffer
// - Receive completion with enable wakes the core
// - Receive flag always; request only when enabled
// - Data in buffer; ninth bit, errors in status
// - Clearing continuous enable clears receive errors
// - Half-duplex; port enable turns pins into clock/data
// - Buffer-empty flag set on transfer, cleared by load
package ssp_pkg;

   typedef logic [2:0] ssp_addr_t;
   typedef logic [7:0] ssp_byte_t;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam ssp_addr_t ADDR_RX_CTRL  = 3'h0;
   localparam ssp_addr_t ADDR_TX_BUF   = 3'h1;
   localparam ssp_addr_t ADDR_TX_CTRL  = 3'h2;
   localparam ssp_addr_t ADDR_BAUD     = 3'h3;
   localparam ssp_addr_t ADDR_IRQ_FLAG = 3'h4;
   localparam ssp_addr_t ADDR_IRQ_EN   = 3'h5;
   localparam ssp_addr_t ADDR_IRQ_PRIO = 3'h6;
   localparam ssp_addr_t ADDR_RX_BUF   = 3'h7;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int RX_PORT_EN = 7;
   localparam int RX_NINE    = 6;
   localparam int RX_SINGLE  = 5;
   localparam int RX_CONT    = 4;
   localparam int RX_FRAME   = 2;
   localparam int RX_OVERRUN = 1;
   localparam int RX_NINTH   = 0;
   localparam int TX_CLK_SRC = 7;
   localparam int TX_NINE    = 6;
   localparam int TX_ENABLE  = 5;
   localparam int TX_SYNC    = 4;
   localparam int TX_BRGH    = 2;
   localparam int TX_EMPTY   = 1;
   localparam int TX_NINTH   = 0;
   localparam int IRQ_RX     = 5;
   localparam int IRQ_TX     = 4;

   // ----------------------------------------------------------------
   // Reset values and word lengths
   // ----------------------------------------------------------------
   localparam ssp_byte_t  RST_BYTE   = 8'h00;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE  = 4'h9;
   localparam logic [3:0] CNT_ZERO   = 4'h0;
   localparam logic [3:0] CNT_ONE    = 4'h1;

   // Link activity selection
   typedef enum logic [1:0]
   {
      SSP_IDLE = 2'b00,
      SSP_TX   = 2'b01,
      SSP_RX   = 2'b10
   } ssp_mode_t;

   // Bits per word for the selected width
   function automatic logic [3:0] ssp_word_bits(input logic nine);
      return nine ? BITS_NINE : BITS_EIGHT;
   endfunction

endpackage

// ==== design/ssp_port.sv ====
// Purpose : Synchronous half-duplex serial port, master and slave
// Assumes : Pins arrive asynchronous and are synchronised here
// Notes   : Output enables are active low; clock idles low
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ssp_port
(
   input  wire logic               sys_clk_i,
   input  wire logic               nrst_i,
   input  wire ssp_pkg::ssp_addr_t reg_addr_i,
   input  wire ssp_pkg::ssp_byte_t reg_wdata_i,
   input  wire logic               reg_we_i,
   input  wire logic               reg_re_i,
   output var  ssp_pkg::ssp_byte_t reg_rdata_o,
   input  wire logic               low_power_i,
   input  wire logic               shift_clock_pin_i,
   output var  logic               shift_clock_pin_o,
   output var  logic               shift_clock_pin_oe_n_o,
   input  wire logic               serial_data_pin_i,
   output var  logic               serial_data_pin_o,
   output var  logic               serial_data_pin_oe_n_o,
   output var  logic               rx_irq_o,
   output var  logic               tx_irq_o,
   output var  logic               wake_o
);
   import ssp_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic       serial_port_enable;
   logic       nine_bit_rx_select;
   logic       single_word_rx_enable;
   logic       continuous_rx_enable;
   logic       overrun_error;
   logic       rx_ninth_bit;
   logic       clock_source_select;
   logic       nine_bit_tx_select;
   logic       transmitter_enable;
   logic       sync_mode;
   logic       brgh;
   logic       tx_ninth_bit;
   ssp_byte_t  baud_rate_divisor;
   logic       rx_irq_enable;
   logic       tx_irq_enable;
   logic       rx_irq_prio;
   logic       tx_irq_prio;
   ssp_byte_t  receive_buffer;
   logic       rx_complete_flag;
   ssp_byte_t  transmit_buffer;
   logic       tx_buf_full;
   logic [8:0] transmit_shifter;
   logic [3:0] tx_count;
   logic       tx_busy;
   logic [8:0] receive_shifter;
   logic [3:0] rx_count;
   logic       sclk_meta;
   logic       sclk_sync;
   logic       sclk_prev;
   logic       data_meta;
   logic       data_sync;
   logic       data_prev;
   logic       link_on;
   logic       rx_request;
   ssp_mode_t  mode;
   logic       shift_fall;
   logic       gen_fall;
   logic       pin_fall;
   logic       tx_done;
   logic       tx_load;
   logic       rx_done;
   logic       rx_buf_read;
   logic       tx_buffer_empty_flag;
   logic [8:0] rx_word;

   ssp_baud_if bif ();

   ssp_baud_gen u_baud
   (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .bif       (bif)
   );

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Two flops per pin, then one more for edges and data alignment
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         sclk_meta <= 1'b0;
         sclk_sync <= 1'b0;
         sclk_prev <= 1'b0;
         data_meta <= 1'b0;
         data_sync <= 1'b0;
         data_prev <= 1'b0;
      end
      else
      begin
         sclk_meta <= shift_clock_pin_i;
         sclk_sync <= sclk_meta;
         sclk_prev <= sclk_sync;
         data_meta <= serial_data_pin_i;
         data_sync <= data_meta;
         data_prev <= data_sync;
      end
   end

   // ----------------------------------------------------------------
   // Mode selection and shift events
   // ----------------------------------------------------------------
   // Port active only with port enable and synchronous mode
   assign link_on = serial_port_enable & sync_mode;

   // slave listens to continuous enable only
   assign rx_request = clock_source_select ?
                       (continuous_rx_enable | single_word_rx_enable) :
                       continuous_rx_enable;

   // Receive and transmit never share the link
   always_comb
   begin
      mode = SSP_IDLE;
      if (link_on && rx_request)
      begin
         mode = SSP_RX;
      end
      else if (link_on && transmitter_enable)
      begin
         mode = SSP_TX;
      end
   end

   // clock source picks internal or external edges
   assign gen_fall = bif.tick & shift_clock_pin_o;
   // slave edges come from the external clock pin
   assign pin_fall = sclk_prev & ~sclk_sync;
   // every data step happens on a falling edge
   assign shift_fall = clock_source_select ? gen_fall : pin_fall;

   assign tx_done = (mode == SSP_TX) && tx_busy && shift_fall && (tx_count == CNT_ONE);
   // shifter takes the buffer as soon as it is free
   assign tx_load = (mode == SSP_TX) && tx_buf_full && (!tx_busy || tx_done);
   assign rx_done = (mode == SSP_RX) && shift_fall &&
                    (rx_count == ssp_word_bits(nine_bit_rx_select) - CNT_ONE);
   assign rx_buf_read = reg_re_i && (reg_addr_i == ADDR_RX_BUF);
   // flag is the inverse of buffer occupancy
   assign tx_buffer_empty_flag = ~tx_buf_full;
   // Slave edges are seen a flop late, so slave data is taken a flop later
   assign rx_word = {clock_source_select ? data_sync : data_prev, receive_shifter[8:1]};

   // ----------------------------------------------------------------
   // Master clock generation
   // ----------------------------------------------------------------
   // divider runs only while a word is being shifted
   assign bif.run = link_on & clock_source_select & ~low_power_i &
                    ((mode == SSP_TX && tx_busy) || mode == SSP_RX);
   assign bif.divisor = baud_rate_divisor;

   // Clock toggles on each tick, drops low when stopped
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i || !bif.run)
      begin
         shift_clock_pin_o <= 1'b0;
      end
      else if (bif.tick)
      begin
         shift_clock_pin_o <= ~shift_clock_pin_o;
      end
   end

   // Pin direction: master drives clock, transmitter drives data
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         shift_clock_pin_oe_n_o <= 1'b1;
         serial_data_pin_oe_n_o <= 1'b1;
      end
      else
      begin
         // port enable turns pins into clock and data
         shift_clock_pin_oe_n_o <= ~(link_on & clock_source_select);
         serial_data_pin_oe_n_o <= ~(mode == SSP_TX);
      end
   end

   // ----------------------------------------------------------------
   // Transmit path
   // ----------------------------------------------------------------
   // Buffer fills on software write, empties into the shifter
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         transmit_buffer <= RST_BYTE;
         tx_buf_full     <= 1'b0;
      end
      else if (reg_we_i && reg_addr_i == ADDR_TX_BUF)
      begin
         // only a data load clears the empty flag
         transmit_buffer <= reg_wdata_i;
         tx_buf_full     <= 1'b1;
      end
      else if (tx_load)
      begin
         // empty flag rises when the waiting word moves on
         tx_buf_full <= 1'b0;
      end
   end

   // Shifter: LSB first, next bit presented after each falling edge
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         transmit_shifter  <= 9'h000;
         tx_count          <= CNT_ZERO;
         tx_busy           <= 1'b0;
         serial_data_pin_o <= 1'b0;
      end
      else if (tx_load)
      begin
         // ninth bit captured from control at load time
         transmit_shifter  <= {tx_ninth_bit, transmit_buffer};
         tx_count          <= ssp_word_bits(nine_bit_tx_select);
         tx_busy           <= 1'b1;
         serial_data_pin_o <= transmit_buffer[0];
      end
      else if (mode != SSP_TX || tx_done)
      begin
         tx_busy  <= 1'b0;
         tx_count <= CNT_ZERO;
      end
      else if (tx_busy && shift_fall)
      begin
         // slave shifts whatever the core power state
         transmit_shifter  <= {1'b0, transmit_shifter[8:1]};
         tx_count          <= tx_count - CNT_ONE;
         serial_data_pin_o <= transmit_shifter[1];
      end
   end

   // ----------------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------------
   // Bit counter cleared whenever receive is off; shifter keeps its contents
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         receive_shifter <= 9'h000;
         rx_count        <= CNT_ZERO;
      end
      else if (mode != SSP_RX || rx_done)
      begin
         rx_count <= CNT_ZERO;
      end
      else if (shift_fall)
      begin
         // data sampled at the falling edge
         receive_shifter <= rx_word;
         rx_count        <= rx_count + CNT_ONE;
      end
   end

   // Completed word into buffer, flag set, overrun if unread
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         receive_buffer   <= RST_BYTE;
         rx_ninth_bit     <= 1'b0;
         rx_complete_flag <= 1'b0;
      end
      else if (rx_done && !(rx_complete_flag && !rx_buf_read))
      begin
         // finished word moves into the buffer
         // slave completes words during sleep or idle
         receive_buffer   <= nine_bit_rx_select ? rx_word[7:0] : rx_word[8:1];
         // ninth bit lands in the status register
         rx_ninth_bit     <= nine_bit_rx_select & rx_word[8];
         // flag set on every completed word
         rx_complete_flag <= 1'b1;
      end
      else if (rx_buf_read)
      begin
         rx_complete_flag <= 1'b0;
      end
   end

   // Overrun: word finished while the previous one is unread
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         overrun_error <= 1'b0;
      end
      else if (rx_done && rx_complete_flag && !rx_buf_read)
      begin
         overrun_error <= 1'b1;
      end
      else if (reg_we_i && reg_addr_i == ADDR_RX_CTRL && !reg_wdata_i[RX_CONT])
      begin
         // dropping continuous enable clears the error
         overrun_error <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Receive control; single-word enable self-clears in master mode
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         serial_port_enable    <= 1'b0;
         nine_bit_rx_select    <= 1'b0;
         single_word_rx_enable <= 1'b0;
         continuous_rx_enable  <= 1'b0;
      end
      else if (reg_we_i && reg_addr_i == ADDR_RX_CTRL)
      begin
         serial_port_enable    <= reg_wdata_i[RX_PORT_EN];
         nine_bit_rx_select    <= reg_wdata_i[RX_NINE];
         single_word_rx_enable <= reg_wdata_i[RX_SINGLE];
         // continuous enable stays until software clears it
         continuous_rx_enable  <= reg_wdata_i[RX_CONT];
      end
      // one word then stop, continuous keeps going
      else if (rx_done && clock_source_select && !continuous_rx_enable)
      begin
         single_word_rx_enable <= 1'b0;
      end
   end

   // Transmit control, divisor, enables and priorities
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         clock_source_select <= 1'b0;
         nine_bit_tx_select  <= 1'b0;
         transmitter_enable  <= 1'b0;
         sync_mode           <= 1'b0;
         brgh                <= 1'b0;
         tx_ninth_bit        <= 1'b0;
         baud_rate_divisor   <= RST_BYTE;
         rx_irq_enable       <= 1'b0;
         tx_irq_enable       <= 1'b0;
         rx_irq_prio         <= 1'b0;
         tx_irq_prio         <= 1'b0;
      end
      else if (reg_we_i)
      begin
         unique case (reg_addr_i)
            ADDR_TX_CTRL:
            begin
               clock_source_select <= reg_wdata_i[TX_CLK_SRC];
               nine_bit_tx_select  <= reg_wdata_i[TX_NINE];
               transmitter_enable  <= reg_wdata_i[TX_ENABLE];
               sync_mode           <= reg_wdata_i[TX_SYNC];
               brgh                <= reg_wdata_i[TX_BRGH];
               tx_ninth_bit        <= reg_wdata_i[TX_NINTH];
            end
            ADDR_BAUD: baud_rate_divisor <= reg_wdata_i;
            ADDR_IRQ_EN:
            begin
               rx_irq_enable <= reg_wdata_i[IRQ_RX];
               tx_irq_enable <= reg_wdata_i[IRQ_TX];
            end
            ADDR_IRQ_PRIO:
            begin
               rx_irq_prio <= reg_wdata_i[IRQ_RX];
               tx_irq_prio <= reg_wdata_i[IRQ_TX];
            end
            default:
            begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register read and request outputs
   // ----------------------------------------------------------------
   // Read data one cycle after the strobe, reserved bits zero
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         reg_rdata_o <= RST_BYTE;
      end
      else if (reg_re_i)
      begin
         reg_rdata_o <= RST_BYTE;
         unique case (reg_addr_i)
            ADDR_RX_CTRL:
            begin
               // status carries ninth bit and overrun error
               reg_rdata_o[RX_PORT_EN] <= serial_port_enable;
               reg_rdata_o[RX_NINE]    <= nine_bit_rx_select;
               reg_rdata_o[RX_SINGLE]  <= single_word_rx_enable;
               reg_rdata_o[RX_CONT]    <= continuous_rx_enable;
               reg_rdata_o[RX_OVERRUN] <= overrun_error;
               reg_rdata_o[RX_NINTH]   <= rx_ninth_bit;
            end
            ADDR_TX_BUF: reg_rdata_o <= transmit_buffer;
            ADDR_TX_CTRL:
            begin
               reg_rdata_o[TX_CLK_SRC] <= clock_source_select;
               reg_rdata_o[TX_NINE]    <= nine_bit_tx_select;
               reg_rdata_o[TX_ENABLE]  <= transmitter_enable;
               reg_rdata_o[TX_SYNC]    <= sync_mode;
               reg_rdata_o[TX_BRGH]    <= brgh;
               reg_rdata_o[TX_EMPTY]   <= ~tx_busy;
               reg_rdata_o[TX_NINTH]   <= tx_ninth_bit;
            end
            ADDR_BAUD: reg_rdata_o <= baud_rate_divisor;
            ADDR_IRQ_FLAG:
            begin
               reg_rdata_o[IRQ_RX] <= rx_complete_flag;
               reg_rdata_o[IRQ_TX] <= tx_buffer_empty_flag;
            end
            ADDR_IRQ_EN:
            begin
               reg_rdata_o[IRQ_RX] <= rx_irq_enable;
               reg_rdata_o[IRQ_TX] <= tx_irq_enable;
            end
            ADDR_IRQ_PRIO:
            begin
               reg_rdata_o[IRQ_RX] <= rx_irq_prio;
               reg_rdata_o[IRQ_TX] <= tx_irq_prio;
            end
            ADDR_RX_BUF: reg_rdata_o <= receive_buffer;
         endcase
      end
   end

   // Interrupt requests gated by enables; wake only in low power
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         rx_irq_o <= 1'b0;
         tx_irq_o <= 1'b0;
         wake_o   <= 1'b0;
      end
      else
      begin
         // request only with the receive enable
         rx_irq_o <= rx_complete_flag & rx_irq_enable;
         tx_irq_o <= tx_buffer_empty_flag & tx_irq_enable;
         // empty flag wakes the core, so does receive
         wake_o   <= low_power_i & ((rx_complete_flag & rx_irq_enable) |
                                    (tx_buffer_empty_flag & tx_irq_enable));
      end
   end

endmodule
`default_nettype wire

// ==== tb/ssp_peer.sv ====
// Purpose: Serial peer on the clock and data pins
// Assumes: LSB first, eight-bit words
// Notes: Link clock stays low outside frames
`timescale 1ns/1ns
`default_nettype none
module ssp_peer
(
   input  wire logic ck_i,
   input  wire logic dt_i,
   output var  logic ck_o,
   output var  logic dt_o
);
   logic [7:0] sh = 8'h00;
   logic [7:0] got = 8'h00;
   int         idx = 8;
   initial ck_o = 1'b0;
   initial dt_o = 1'b0;
   // data moves on rise, steady at fall
   always @(posedge ck_i)
   begin
      if (idx < 8)
      begin
         dt_o = sh[idx];
         got[idx] = dt_i;
      end
   end
   // Count falls; stale bit inverted after a word
   always @(negedge ck_i)
   begin
      idx = idx + 1;
      if (idx == 8)
      begin
         idx = 0;
         dt_o = ~dt_o;
      end
   end
   task automatic load(input logic [7:0] b);
      sh = b;
      idx = 0;
      dt_o = b[0];
   endtask
   task automatic frame();
      #3;
      repeat (8)
      begin
         #32 ck_o = 1'b1;
         #32 ck_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/ssp_port_chk.sv ====
// Purpose: Port-level checks of the serial port
// Assumes: Sees only top-level ports
// Notes: Bound below
`timescale 1ns/1ns
`default_nettype none
module ssp_port_chk
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   input wire logic low_power_i,
   input wire logic shift_clock_pin_o,
   input wire logic shift_clock_pin_oe_n_o,
   input wire logic serial_data_pin_oe_n_o,
   input wire logic rx_irq_o,
   input wire logic tx_irq_o,
   input wire logic wake_o
);
   logic [2:0] ac_h;
   // Recent register accesses
   always_ff @(posedge sys_clk_i)
   begin
      ac_h <= {ac_h[1:0], reg_we_i | reg_re_i};
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   // Requests and wake-up
   a_rxirq_fall: assert property ($fell(rx_irq_o) |-> |ac_h)
      else $error("rx request fell unprompted");
   a_txirq_fall: assert property ($fell(tx_irq_o) |-> |ac_h)
      else $error("tx request fell unprompted");
   a_wake_cause: assert property (wake_o |-> $past(low_power_i))
      else $error("wake while awake");
   a_wake_rx: assert property ($past(low_power_i) && rx_irq_o && $past(rx_irq_o) |-> wake_o)
      else $error("no wake on rx");
   a_wake_tx: assert property ($past(low_power_i) && tx_irq_o && $past(tx_irq_o) |-> wake_o)
      else $error("no wake on tx");
   // Pin direction and clock
   a_clkoe_write: assert property ($changed(shift_clock_pin_oe_n_o) |-> |ac_h)
      else $error("clock direction moved");
   a_dataoe_write: assert property ($fell(serial_data_pin_oe_n_o) |-> |ac_h)
      else $error("data drive began");
   a_clk_master: assert property ($rose(shift_clock_pin_o) |-> !shift_clock_pin_oe_n_o)
      else $error("clock toggled undriven");
   c_rx_word: cover property ($rose(rx_irq_o));
   c_tx_irq: cover property ($rose(tx_irq_o));
   c_wake: cover property ($rose(wake_o));
endmodule
bind ssp_port ssp_port_chk i_chk (.sys_clk_i, .nrst_i, .reg_we_i, .reg_re_i, .low_power_i,
   .shift_clock_pin_o, .shift_clock_pin_oe_n_o, .serial_data_pin_oe_n_o, .rx_irq_o,
   .tx_irq_o, .wake_o);
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the serial port
// Assumes: Peer model on the pins
// Notes: Divisor 3 in master mode
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
$display("wrong value %s exp %h got %h", n, e, s); end end
module testbench;
   import ssp_pkg::*;
   logic      clk = 1'b0;
   logic      nrst = 1'b0;
   logic      we = 1'b0;
   logic      re = 1'b0;
   logic      lp = 1'b0;
   ssp_addr_t addr = 3'h0;
   ssp_byte_t wdata = 8'h00;
   ssp_byte_t rdata;
   logic      ck_o, ck_oe_n, dt_o, dt_oe_n, pk, pd, rx_irq, tx_irq, wake;
   int        errors = 0;
   int        cmp_count = 0;
   // Clock and pin resolution
   always #2 clk = ~clk;
   wire       ck = ck_oe_n ? pk : ck_o;
   wire       dt = dt_oe_n ? pd : dt_o;
   ssp_port i_dut (.sys_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .low_power_i(lp),
      .shift_clock_pin_i(ck), .shift_clock_pin_o(ck_o), .shift_clock_pin_oe_n_o(ck_oe_n),
      .serial_data_pin_i(dt), .serial_data_pin_o(dt_o), .serial_data_pin_oe_n_o(dt_oe_n),
      .rx_irq_o(rx_irq), .tx_irq_o(tx_irq), .wake_o(wake));
   ssp_peer i_peer (.ck_i(ck), .dt_i(dt), .ck_o(pk), .dt_o(pd));
   task automatic rst();
      @(posedge clk);
      nrst <= 1'b0;
      lp <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
   endtask
   task automatic wr(input ssp_addr_t a, input ssp_byte_t d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask
   task automatic rd(input ssp_addr_t a, input ssp_byte_t m, input ssp_byte_t e, input string n);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      @(posedge clk);
      re <= 1'b0;
      #1 `CHK(n, e, rdata & m)
   endtask
   // Bounded wait on rx request, tx request or wake
   task automatic wt(input int k, input string n);
      logic s;
      s = 1'b0;
      repeat (400)
      begin
         @(posedge clk);
         s = (k == 0) ? rx_irq : (k == 1) ? tx_irq : wake;
         if (s === 1'b1)
            break;
      end
      `CHK(n, 1'b1, s)
   endtask
   // Clock must stay low for a while
   task automatic quiet(input string n);
      int r;
      r = 0;
      repeat (60)
      begin
         @(posedge clk);
         r += (ck_o !== 1'b0);
      end
      `CHK(n, 0, r)
   endtask
   task automatic s_master_rx();
      rd(ADDR_TX_CTRL, 8'hff, 8'h02, "tx ctrl");
      rd(ADDR_IRQ_FLAG, 8'hff, 8'h10, "flags");
      wr(ADDR_BAUD, 8'h03);
      wr(ADDR_TX_CTRL, 8'h90);
      wr(ADDR_IRQ_EN, 8'h20);
      wr(ADDR_RX_CTRL, 8'h80);
      quiet("idle clock");
      i_peer.load(8'ha5);
      wr(ADDR_RX_CTRL, 8'ha0);
      wt(0, "rx irq");
      rd(ADDR_RX_BUF, 8'hff, 8'ha5, "rx data");
      quiet("after single");
      rd(ADDR_RX_CTRL, 8'hff, 8'h80, "single clr");
      i_peer.load(8'h3c);
      wr(ADDR_RX_CTRL, 8'hb0);
      repeat (200) @(posedge clk);
      rd(ADDR_RX_CTRL, 8'hdf, 8'h92, "overrun");
      rd(ADDR_RX_BUF, 8'hff, 8'h3c, "cont data");
      wr(ADDR_RX_CTRL, 8'h80);
      repeat (80) @(posedge clk);
      quiet("cont stop");
      rd(ADDR_RX_CTRL, 8'hff, 8'h80, "err clr");
   endtask
   task automatic s_slave_rx();
      wr(ADDR_TX_CTRL, 8'h10);
      wr(ADDR_IRQ_EN, 8'h20);
      wr(ADDR_RX_CTRL, 8'ha0);
      i_peer.load(8'h5a);
      i_peer.frame();
      repeat (8) @(posedge clk);
      `CHK("single slave", 1'b0, rx_irq)
      wr(ADDR_RX_CTRL, 8'h90);
      lp <= 1'b1;
      i_peer.load(8'h5a);
      i_peer.frame();
      wt(2, "rx wake");
      rd(ADDR_RX_BUF, 8'hff, 8'h5a, "slave data");
   endtask
   task automatic s_slave_tx();
      wr(ADDR_RX_CTRL, 8'h80);
      wr(ADDR_TX_CTRL, 8'h30);
      wr(ADDR_IRQ_EN, 8'h10);
      wr(ADDR_TX_BUF, 8'h81);
      wr(ADDR_TX_BUF, 8'h7e);
      rd(ADDR_IRQ_FLAG, 8'hff, 8'h00, "flag held");
      `CHK("tx irq low", 1'b0, tx_irq)
      @(posedge clk);
      lp <= 1'b1;
      i_peer.frame();
      `CHK("first out", 8'h81, i_peer.got)
      wt(2, "tx wake");
      `CHK("tx irq", 1'b1, tx_irq)
      i_peer.frame();
      `CHK("second out", 8'h7e, i_peer.got)
      wr(ADDR_IRQ_FLAG, 8'h00);
      rd(ADDR_IRQ_FLAG, 8'hff, 8'h10, "flag kept");
   endtask
   task automatic print_verdict();
      $display("compares %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      rst();
      s_master_rx();
      rst();
      s_slave_rx();
      rst();
      s_slave_tx();
      print_verdict();
   end
   // Watchdog
   initial
   begin
      #200000;
      errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
